// ==== include/ssprd_defs.svh ====
// Purpose: Constants of the swept sensor pixel readout.
// Assumes: 25 MHz system clock; pixel clock driven by the host.
// Notes: Definitions only.
`ifndef SSPRD_DEFS_SVH
`define SSPRD_DEFS_SVH

// Array geometry: 280 true columns plus one extra column
`define SSPRD_LAST_COL 9'h118
`define SSPRD_LAST_PAIR 2'h3
`define SSPRD_COL_W 9
`define SSPRD_PAIR_W 2

// Pixel clock pulses spent filling the conversion pipeline
`define SSPRD_FILL_PULSES 3'h4

// Converter widths
`define SSPRD_LEVEL_W 8
`define SSPRD_CODE_W 4

// Output buffer depth
`define SSPRD_FIFO_DEPTH 32

// Quiet window after each pixel clock fall, in ns, and in system cycles
`define SSPRD_CLK_MHZ 25
`define SSPRD_QUIET_NS 100
`define SSPRD_QUIET_CYC ((`SSPRD_QUIET_NS * `SSPRD_CLK_MHZ + 999) / 1000)

`endif

// ==== include/ssprd_pkg.sv ====
// Purpose: Types of the swept sensor pixel readout.
// Assumes: Nothing beyond the defs header.
// Notes: Used by name, never imported.
package ssprd_pkg;

  // Readout sequencer states, one-hot
  typedef enum logic [2:0] {
    SSPRD_ST_HOLD = 3'h1,
    SSPRD_ST_FILL = 3'h2,
    SSPRD_ST_READ = 3'h4
  } ssprd_state_type;

endpackage : ssprd_pkg

// ==== verilog/ssprd_fifo.sv ====
// Purpose: Synchronous FIFO between the converters and the output stage.
// Assumes: One clock; flush empties it in one cycle.
// Notes: Full and empty are exact; a write while full is refused.
`timescale 1ns/1ps
`default_nettype none

module ssprd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic do_wr;
  logic do_rd;

  // Handshakes
  assign in_ready_o = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr_r];

  // Storage
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || flush_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_r <= count_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : ssprd_fifo

`default_nettype wire

// ==== verilog/ssprd_pair_conv.sv ====
// Purpose: Two independent converters for the odd and even line levels.
// Assumes: Levels arrive as unsigned codes from the line amplifiers.
// Notes: One cycle latency; both results carry one shared valid.
`timescale 1ns/1ps
`default_nettype none

module ssprd_pair_conv #(
  parameter int LEVEL_W = 8,
  parameter int CODE_W = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sample request and levels
  input wire logic sample_i,
  input wire logic [LEVEL_W-1:0] odd_level_i,
  input wire logic [LEVEL_W-1:0] even_level_i,
  // Results
  output logic valid_o,
  output logic [CODE_W-1:0] odd_code_o,
  output logic [CODE_W-1:0] even_code_o
);

  // Quantise a level to the converter resolution
  function automatic logic [CODE_W-1:0] quantise(input logic [LEVEL_W-1:0] lvl);
    quantise = lvl[LEVEL_W-1 -: CODE_W];
  endfunction : quantise

  // Result valid strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
    end else begin
      valid_o <= sample_i;
    end
  end

  // Both conversions at once
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      odd_code_o <= '0;
      even_code_o <= '0;
    end else if (sample_i) begin
      odd_code_o <= quantise(odd_level_i);
      even_code_o <= quantise(even_level_i);
    end
  end

endmodule : ssprd_pair_conv

`default_nettype wire

// ==== verilog/ssprd_readout.sv ====
// Purpose: Digital readout of a swept thermal sensor array, column by column.
// Assumes: Pixel clock, sensor reset and output enable come from the host
//   and are synchronous to REF_CLK_I.
// Notes: Pixel clock falls sample and advance; rises present the next byte.
// Contract
// R1 - Select one column at a time out of 280 plus one extra.
// R2 - Pick one odd and one even line together per pixel clock.
// R3 - Two independent 4-bit converters give one pixel pair per pulse.
// R4 - Pack both 4-bit results into one byte per pulse.
// R5 - Frames follow one another without reset while clocking continues.
// R6 - Host pulses reset high then low, then gives 4 fill pulses.
// R7 - Host keeps output enable stable 100 ns after each clock fall.
// R8 - Pixel integration restart is independent of the reset input.
// R9 - A frame is 281 columns of four bytes, 1124 pulses.
// R10 - Clock taken on falling edge, data updated on rising edge.
// R11 - Odd pixel on odd nibble bus, even pixel on even nibble bus.
// R12 - Enable low drives both buses; high releases both.
// R13 - After the extra column's last byte, wrap to the first column.
`include "ssprd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ssprd_readout #(
  parameter int FIFO_DEPTH = `SSPRD_FIFO_DEPTH,
  parameter int LEVEL_W = `SSPRD_LEVEL_W
) (
  // System clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  // Host control pins
  input wire logic PCLK_I,
  input wire logic SENSOR_RST_I,
  input wire logic OUT_EN_N_I,
  // Array selection
  output logic [`SSPRD_COL_W-1:0] COL_SEL_O,
  output logic [`SSPRD_PAIR_W-1:0] LINE_PAIR_O,
  // Amplified levels of the selected pair
  input wire logic [LEVEL_W-1:0] AMP_ODD_I,
  input wire logic [LEVEL_W-1:0] AMP_EVEN_I,
  // Integration restart of a finished column
  output logic INTEG_RESTART_O,
  output logic [`SSPRD_COL_W-1:0] INTEG_COL_O,
  // Odd nibble bus
  output logic [`SSPRD_CODE_W-1:0] ODD_NIBBLE_OUT_O,
  output logic ODD_NIBBLE_OE_O,
  // Even nibble bus
  output logic [`SSPRD_CODE_W-1:0] EVEN_NIBBLE_OUT_O,
  output logic EVEN_NIBBLE_OE_O,
  // Host timing monitor
  output logic QUIET_VIOL_O
);

  localparam int CW = `SSPRD_CODE_W;
  localparam logic [2:0] QUIET_CYC = 3'(`SSPRD_QUIET_CYC);

  ssprd_pkg::ssprd_state_type state_r;
  logic pclk_r;
  logic pclk_fall;
  logic pclk_rise;
  logic [2:0] fill_cnt_r;
  logic [`SSPRD_COL_W-1:0] col_r;
  logic [`SSPRD_PAIR_W-1:0] pair_r;
  logic sample;
  logic conv_valid;
  logic [CW-1:0] conv_odd;
  logic [CW-1:0] conv_even;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [2*CW-1:0] fifo_out_data;
  logic [CW-1:0] odd_r;
  logic [CW-1:0] even_r;
  logic integ_r;
  logic [`SSPRD_COL_W-1:0] integ_col_r;
  logic [2:0] quiet_cnt_r;
  logic oe_n_prev_r;
  logic viol_r;

  // Last byte of a frame sits in the extra column, last line pair
  // R9 frame length end
  function automatic logic last_byte(input logic [`SSPRD_COL_W-1:0] col,
                                     input logic [`SSPRD_PAIR_W-1:0] pair);
    last_byte = (col == `SSPRD_LAST_COL) && (pair == `SSPRD_LAST_PAIR);
  endfunction : last_byte

  // Pixel clock edge detection; reset to the stopped-clock level, so no false rise
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      pclk_r <= 1'b1;
    end else begin
      pclk_r <= PCLK_I;
    end
  end

  // R10 falling edge samples
  assign pclk_fall = pclk_r && !PCLK_I;
  assign pclk_rise = !pclk_r && PCLK_I;

  // Sequencer: hold under sensor reset, fill the pipeline, then read
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      state_r <= ssprd_pkg::SSPRD_ST_HOLD;
      fill_cnt_r <= 3'h0;
    end else if (SENSOR_RST_I) begin
      state_r <= ssprd_pkg::SSPRD_ST_HOLD;
      fill_cnt_r <= 3'h0;
    end else begin
      case (state_r)
        ssprd_pkg::SSPRD_ST_HOLD: begin
          state_r <= ssprd_pkg::SSPRD_ST_FILL;
        end
        // R6 fill pulses
        ssprd_pkg::SSPRD_ST_FILL: begin
          if (pclk_fall) begin
            fill_cnt_r <= fill_cnt_r + 3'h1;
            if (fill_cnt_r == `SSPRD_FILL_PULSES - 3'h1) begin
              state_r <= ssprd_pkg::SSPRD_ST_READ;
            end
          end
        end
        // R5 stay reading
        ssprd_pkg::SSPRD_ST_READ: begin
          state_r <= ssprd_pkg::SSPRD_ST_READ;
        end
        default: begin
          state_r <= ssprd_pkg::SSPRD_ST_HOLD;
        end
      endcase
    end
  end

  // A pair is sampled on each fall while reading and the buffer has room
  assign sample = pclk_fall && (state_r == ssprd_pkg::SSPRD_ST_READ) && fifo_in_ready;

  // Column and line pair counters
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I || SENSOR_RST_I) begin
      col_r <= '0;
      pair_r <= '0;
    end else if (sample) begin
      // R13 frame wrap
      if (last_byte(col_r, pair_r)) begin
        col_r <= '0;
        pair_r <= '0;
      // R1 next column
      end else if (pair_r == `SSPRD_LAST_PAIR) begin
        col_r <= col_r + 1'b1;
        pair_r <= '0;
      // R2 next line pair
      end else begin
        pair_r <= pair_r + 1'b1;
      end
    end
  end

  // R1 single column select
  assign COL_SEL_O = col_r;
  // R2 odd and even lines chosen together
  assign LINE_PAIR_O = pair_r;

  // R3 paired converters
  ssprd_pair_conv #(
    .LEVEL_W(LEVEL_W),
    .CODE_W(CW)
  ) ssprd_pair_conv_i (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .sample_i(sample),
    .odd_level_i(AMP_ODD_I),
    .even_level_i(AMP_EVEN_I),
    .valid_o(conv_valid),
    .odd_code_o(conv_odd),
    .even_code_o(conv_even)
  );

  // R4 pair packed into one byte word
  ssprd_fifo #(
    .WIDTH(2 * CW),
    .DEPTH(FIFO_DEPTH)
  ) ssprd_fifo_i (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .flush_i(SENSOR_RST_I),
    .in_valid_i(conv_valid),
    .in_data_i({conv_odd, conv_even}),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(pclk_rise)
  );

  // R10 output byte updated on the rising edge
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I || SENSOR_RST_I) begin
      odd_r <= '0;
      even_r <= '0;
    end else if (pclk_rise && fifo_out_valid) begin
      // R11 nibble split
      odd_r <= fifo_out_data[2*CW-1 -: CW];
      even_r <= fifo_out_data[CW-1:0];
    end
  end

  // R12 drive while enable is low
  assign ODD_NIBBLE_OUT_O = odd_r;
  assign EVEN_NIBBLE_OUT_O = even_r;
  assign ODD_NIBBLE_OE_O = !OUT_EN_N_I;
  assign EVEN_NIBBLE_OE_O = !OUT_EN_N_I;

  // R8 restart after a column's last pair, untouched by sensor reset
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      integ_r <= 1'b0;
      integ_col_r <= '0;
    end else begin
      integ_r <= sample && (pair_r == `SSPRD_LAST_PAIR);
      if (sample && (pair_r == `SSPRD_LAST_PAIR)) begin
        integ_col_r <= col_r;
      end
    end
  end

  assign INTEG_RESTART_O = integ_r;
  assign INTEG_COL_O = integ_col_r;

  // R7 flag enable changes inside the quiet window
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      quiet_cnt_r <= 3'h0;
      oe_n_prev_r <= 1'b1;
      viol_r <= 1'b0;
    end else begin
      oe_n_prev_r <= OUT_EN_N_I;
      viol_r <= (quiet_cnt_r != 3'h0) && (OUT_EN_N_I != oe_n_prev_r);
      if (pclk_fall) begin
        quiet_cnt_r <= QUIET_CYC;
      end else if (quiet_cnt_r != 3'h0) begin
        quiet_cnt_r <= quiet_cnt_r - 3'h1;
      end
    end
  end

  assign QUIET_VIOL_O = viol_r;

  // Checks on the readout
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  sequence s_last_sample;
    sample && last_byte(col_r, pair_r);
  endsequence

  sequence s_frame_start;
    (col_r == '0) && (pair_r == '0);
  endsequence

  property p_col_range;
    col_r <= `SSPRD_LAST_COL;
  endproperty
  a_col_range: assert property (p_col_range) // R1
    else $error("column select beyond extra column");

  property p_pair_step;
    sample && (pair_r != `SSPRD_LAST_PAIR) && !SENSOR_RST_I |=>
      (pair_r == $past(pair_r) + 2'h1) && $stable(col_r);
  endproperty
  a_pair_step: assert property (p_pair_step) // R2
    else $error("line pair did not step within column");

  property p_conv_latency;
    sample |=> conv_valid;
  endproperty
  a_conv_latency: assert property (p_conv_latency) // R3
    else $error("converter result missing one cycle after sample");

  property p_byte_pack;
    pclk_rise && fifo_out_valid && !SENSOR_RST_I |=>
      ({odd_r, even_r} == $past(fifo_out_data));
  endproperty
  a_byte_pack: assert property (p_byte_pack) // R4
    else $error("output byte differs from buffered pair");

  property p_no_reset_needed;
    (state_r == ssprd_pkg::SSPRD_ST_READ) && !SENSOR_RST_I |=>
      (state_r == ssprd_pkg::SSPRD_ST_READ);
  endproperty
  a_no_reset_needed: assert property (p_no_reset_needed) // R5
    else $error("readout left read state without sensor reset");

  property p_fill_done;
    (state_r == ssprd_pkg::SSPRD_ST_FILL) && pclk_fall && !SENSOR_RST_I &&
      (fill_cnt_r == 3'h3) |=> (state_r == ssprd_pkg::SSPRD_ST_READ);
  endproperty
  a_fill_done: assert property (p_fill_done) // R6
    else $error("read not entered after fourth fill pulse");

  property p_integ_restart;
    sample && (pair_r == `SSPRD_LAST_PAIR) |=>
      INTEG_RESTART_O && (INTEG_COL_O == $past(col_r));
  endproperty
  a_integ_restart: assert property (p_integ_restart) // R8
    else $error("integration restart missing for finished column");

  property p_rise_update;
    !$stable({odd_r, even_r}) && !$past(SENSOR_RST_I) |-> $past(pclk_rise);
  endproperty
  a_rise_update: assert property (p_rise_update) // R10
    else $error("output byte changed without a clock rise");

  property p_bus_release;
    OUT_EN_N_I |-> !ODD_NIBBLE_OE_O && !EVEN_NIBBLE_OE_O;
  endproperty
  a_bus_release: assert property (p_bus_release) // R12
    else $error("nibble bus driven while enable high");

  property p_wrap;
    s_last_sample ##0 !SENSOR_RST_I |=> s_frame_start;
  endproperty
  a_wrap: assert property (p_wrap) // R13
    else $error("counters did not wrap after extra column");

endmodule : ssprd_readout

`default_nettype wire

// ==== tb/ssprd_array_model.sv ====
// Purpose: Sensor array model giving the amplified levels of the selected pair.
// Assumes: Levels follow column and pair selection with no delay.
// Notes: Low bits are noise that the converters must drop.
`timescale 1ns/1ps
`default_nettype none

module ssprd_array_model (
  // Selection from the readout
  input wire logic [8:0] col_i,
  input wire logic [1:0] pair_i,
  // Amplified levels
  output logic [7:0] odd_o,
  output logic [7:0] even_o
);
  assign odd_o = {~col_i[1:0], pair_i, 4'h9};
  assign even_o = {~pair_i, col_i[3:2], 4'h6};
endmodule : ssprd_array_model

`default_nettype wire

// ==== tb/ssprd_readout_test.sv ====
// Purpose: Self-checking bench of the readout, host side driven by tasks.
// Assumes: Pixel clock low phase of 8 system cycles, high of at least 9, above the 250 ns minimum.
// Notes: Output buffer shrunk to 4 words.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module ssprd_readout_test;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic pclk = 1'b1;
  logic sens_rst = 1'b0;
  logic oe_n = 1'b0;
  logic [8:0] col_sel, integ_col;
  logic [1:0] line_pair;
  logic [7:0] amp_odd, amp_even;
  logic integ_restart, odd_oe, even_oe, quiet_viol;
  logic [3:0] odd_nib, even_nib;
  int fails = 0;
  int tests_run = 0;
  int restarts = 0;
  int quiet = 0;

  // System clock, 40 ns
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // Count restart and quiet-window pulses
  always @(posedge ref_clk) begin
    if (integ_restart === 1'b1) restarts++;
    if (quiet_viol === 1'b1) quiet++;
  end

  ssprd_readout #(.FIFO_DEPTH(4), .LEVEL_W(8)) ssprd_readout_i (
    .REF_CLK_I(ref_clk), .RESET_N_I(reset_n), .PCLK_I(pclk),
    .SENSOR_RST_I(sens_rst), .OUT_EN_N_I(oe_n), .COL_SEL_O(col_sel),
    .LINE_PAIR_O(line_pair), .AMP_ODD_I(amp_odd), .AMP_EVEN_I(amp_even),
    .INTEG_RESTART_O(integ_restart), .INTEG_COL_O(integ_col),
    .ODD_NIBBLE_OUT_O(odd_nib), .ODD_NIBBLE_OE_O(odd_oe),
    .EVEN_NIBBLE_OUT_O(even_nib), .EVEN_NIBBLE_OE_O(even_oe),
    .QUIET_VIOL_O(quiet_viol));

  ssprd_array_model ssprd_array_model_i (
    .col_i(col_sel), .pair_i(line_pair), .odd_o(amp_odd), .even_o(amp_even));

  // One pixel clock pulse; optionally toggles enable oe_at cycles after the fall
  task automatic pulse(input int oe_at);
    logic [7:0] po;
    @(posedge ref_clk);
    po = {odd_nib, even_nib};
    pclk <= 1'b0;
    for (int i = 1; i <= 8; i++) begin
      @(posedge ref_clk);
      if (i == oe_at) oe_n <= ~oe_n;
    end
    pclk <= 1'b1;
    #1;
    `CHK("byte_hold_low", po, {odd_nib, even_nib})
    repeat (8) @(posedge ref_clk);
  endtask : pulse

  // Byte k of a frame: column k/4, pair k%4
  task automatic exp_byte(input int k);
    logic [8:0] c;
    logic [1:0] p;
    c = 9'(k / 4);
    p = 2'(k % 4);
    `CHK("odd_nib", {~c[1:0], p}, odd_nib)
    `CHK("even_nib", {~p, c[3:2]}, even_nib)
  endtask : exp_byte

  // Reset pin high then low, then four fill pulses
  task automatic start_seq();
    logic [8:0] ic;
    ic = integ_col;
    @(posedge ref_clk) sens_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("rst_odd", 4'h0, odd_nib)
    `CHK("rst_col", 9'h000, col_sel)
    `CHK("integ_kept", ic, integ_col)
    @(posedge ref_clk) sens_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    repeat (4) pulse(0);
  endtask : start_seq

  // Full frame, then wrap into the next without reset
  task automatic t_frame();
    restarts = 0;
    for (int k = 0; k < 1124; k++) begin
      pulse(0);
      exp_byte(k);
    end
    `CHK("restarts", 281, restarts)
    `CHK("integ_col", 9'h118, integ_col)
    `CHK("col_wrap", 9'h000, col_sel)
    `CHK("pair_wrap", 2'h0, line_pair)
    for (int k = 0; k < 8; k++) begin
      pulse(0);
      exp_byte(k);
    end
  endtask : t_frame

  // Enable drives or releases both buses; quiet window monitor
  task automatic t_oe();
    int q;
    @(posedge ref_clk) oe_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK("oe_off", 2'h0, {odd_oe, even_oe})
    @(posedge ref_clk) oe_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK("oe_on", 2'h3, {odd_oe, even_oe})
    q = quiet;
    pulse(2);
    `CHK("quiet_hit", q + 1, quiet)
    q = quiet;
    pulse(6);
    `CHK("quiet_clear", q, quiet)
  endtask : t_oe

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    start_seq();
    t_frame();
    t_oe();
    start_seq();
    pulse(0);
    exp_byte(0);
    print_verdict();
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    $display("[FAIL] watchdog exp done got hang");
    print_verdict();
  end

  // Verdict and end of run
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
endmodule : ssprd_readout_test

`default_nettype wire
